// ---- logic/sewa_pkg.sv ----
// Purpose: constants and types for the two-wire eeprom/wiper host controller
// Assumes: 25 MHz ref_clk; software drives the controller over APB
// Notes:   the host generates the link clock by dividing ref_clk
package sewa_pkg;
  // timing
  localparam int CLK_NS   = 40;        // ref_clk period
  localparam int SCL_NS   = 10000;     // link clock period
  localparam int SCL_Q    = (SCL_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
  localparam int TWR_NS   = 5000000;   // internal write cycle
  localparam int TWR_CYC  = (TWR_NS + CLK_NS - 1) / CLK_NS;
  // slave type identifiers
  localparam logic [6:0] DEV_EE   = 7'h50;  // 1010000
  localparam logic [6:0] DEV_DCP  = 7'h57;  // 1010111
  localparam logic [6:0] DEV_CSR  = 7'h52;  // 1010010
  localparam logic [7:0] CSR_ADDR = 8'hFF;
  localparam logic [1:0] SEL_100  = 2'h1;   // 100-tap pot
  // operations
  localparam logic [2:0] OP_SETADDR = 3'h0;
  localparam logic [2:0] OP_WRITE   = 3'h1;
  localparam logic [2:0] OP_CURRD   = 3'h2;
  localparam logic [2:0] OP_RANDRD  = 3'h3;
  localparam logic [2:0] OP_WIPER   = 3'h4;
  localparam logic [2:0] OP_CSRWR   = 3'h5;
  // register map
  localparam logic [7:0] A_CTRL  = 8'h00;  // [2:0] op [7:4] len-1 [8] go
  localparam logic [7:0] A_ADDR  = 8'h04;  // [7:0] word addr [9:8] pot sel
  localparam logic [7:0] A_STAT  = 8'h08;  // busy done nack err ptr_ok
  localparam logic [7:0] A_RDATA = 8'h0C;
  localparam logic [7:0] A_BUF0  = 8'h10;  // 16 words to 4Ch
  localparam logic [7:0] A_BUFN  = 8'h4C;
  localparam int GO_BIT = 8;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WAIT} sewa_st_t;
  typedef enum logic [2:0] {K_START, K_TX, K_RX, K_STOP, K_END} sewa_kind_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sewa_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sewa_apb_rsp_t;

  typedef struct packed {
    sewa_st_t        st;
    logic [1:0]      ph;
    logic [7:0]      qcnt;
    logic [4:0]      step;
    logic [3:0]      bitn;
    logic [7:0]      sh;
    logic            abort;
    logic [2:0]      op;
    logic [3:0]      lenm1;
    logic [7:0]      waddr;
    logic [1:0]      sel;
    logic [7:0]      rdata;
    logic            done;
    logic            nack;
    logic            err;
    logic            ptr_ok;
    logic [16:0]     wcnt;
    logic            sda_m;
    logic            sda_s;
    logic            scl_m;
    logic            scl_s;
    logic            scl_oe;
    logic            sda_oe;
    logic            pin_lo;
    sewa_apb_rsp_t   rsp;
    logic [15:0][7:0] wbuf;
  } sewa_state_t;
endpackage

// ---- logic/sewa_host.sv ----
// Purpose: two-wire host for eeprom array and wiper read-back
// Assumes: open-drain pins; outside logic resolves the wires
// Notes:   one operation at a time; done, nack and err status flags are write-one-clear
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module sewa_host #(
  parameter int WR_WAIT_CYC = sewa_pkg::TWR_CYC  // write busy wait
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire sewa_pkg::sewa_apb_req_t apb_req,
  output      sewa_pkg::sewa_apb_rsp_t apb_rsp,
  input  wire logic                    scl_i,
  output      logic                    scl_o,
  output      logic                    scl_oe,
  input  wire logic                    sda_i,
  output      logic                    sda_o,
  output      logic                    sda_oe
);
  import sewa_pkg::*;

  sewa_state_t s_q;    // all registered state
  sewa_state_t s_d;    // its next value
  sewa_kind_t  kind;   // current link step
  logic        tick;   // end of a quarter bit
  logic        setup;  // apb setup cycle
  logic        acc;    // apb access completes
  logic        wr;     // completed write
  logic        go;     // start request
  logic        mapped; // address decodes

  // step kind for each operation and step index
  function automatic sewa_kind_t step_kind(logic [2:0] op, logic [4:0] i,
                                           logic [3:0] lenm1);
    logic [4:0] lim;
    lim = 5'd4 + ((op == OP_CSRWR) ? 5'd0 : {1'b0, lenm1});
    step_kind = K_END;
    if (i == 5'd0) begin
      step_kind = K_START;
    end else begin
      case (op)
        OP_CURRD: begin
          // address, one byte, stop
          if (i == 5'd1) step_kind = K_TX;
          else if (i == 5'd2) step_kind = K_RX;
          else if (i == 5'd3) step_kind = K_STOP;
        end
        OP_RANDRD, OP_WIPER: begin
          // dummy write, restart, read
          if (i == 5'd3) step_kind = K_START;
          else if (i == 5'd5) step_kind = K_RX;
          else if (i == 5'd6) step_kind = K_STOP;
          else if (i < 5'd5) step_kind = K_TX;
        end
        OP_SETADDR: begin
          // stop straight after the address
          if (i < 5'd3) step_kind = K_TX;
          else if (i == 5'd3) step_kind = K_STOP;
        end
        default: begin
          // write: stop after the last data acknowledge
          if (i < lim) step_kind = K_TX;
          else if (i == lim) step_kind = K_STOP;
        end
      endcase
    end
  endfunction

  // byte sent at a transmit step
  function automatic logic [7:0] tx_byte(logic [2:0] op, logic [4:0] i,
                                         logic [7:0] wa, logic [1:0] sel,
                                         logic [15:0][7:0] b);
    logic [6:0] dev;
    logic [4:0] bi;
    dev = (op == OP_WIPER) ? DEV_DCP : (op == OP_CSRWR) ? DEV_CSR : DEV_EE;
    bi  = i - 5'd3;
    if ((op == OP_WRITE || op == OP_CSRWR) && i >= 5'd3) begin
      tx_byte = b[bi[3:0]];
    end else begin
      case (i)
        5'd1:    tx_byte = {dev, op == OP_CURRD};
        5'd2: begin
          if (op == OP_WIPER) tx_byte = {6'h00, sel};
          else if (op == OP_CSRWR) tx_byte = CSR_ADDR;
          else tx_byte = wa;
        end
        default: tx_byte = {dev, 1'b1};
      endcase
    end
  endfunction

  // buffer slot of a word address in the data window, first word is slot 0
  function automatic logic [3:0] buf_idx(logic [7:0] a);
    logic [7:0] off;
    off     = a - A_BUF0;
    buf_idx = off[5:2];
  endfunction

  assign kind   = (s_q.abort && s_q.bitn == 4'd0) ? K_STOP
                : step_kind(s_q.op, s_q.step, s_q.lenm1);
  assign tick   = (s_q.qcnt == 8'(SCL_Q - 1)) && (s_q.ph != 2'd1 || s_q.scl_s);
  assign setup  = apb_req.psel && !apb_req.penable;
  assign acc    = apb_req.psel && apb_req.penable && s_q.rsp.pready;
  assign wr     = acc && apb_req.pwrite;
  assign go     = wr && apb_req.paddr == A_CTRL && apb_req.pwdata[GO_BIT];
  assign mapped = apb_req.paddr[1:0] == 2'h0 && apb_req.paddr <= A_BUFN;

  // next state
  always_comb begin
    s_d = s_q;
    // two-flop synchronisers for the pins
    s_d.sda_m = sda_i;
    s_d.sda_s = s_q.sda_m;
    s_d.scl_m = scl_i;
    s_d.scl_s = s_q.scl_m;
    // apb slave: one wait-free access cycle
    s_d.rsp.pready  = setup;
    s_d.rsp.pslverr = setup && !mapped;
    s_d.rsp.prdata  = 32'h0;
    if (setup && !apb_req.pwrite) begin
      if (apb_req.paddr == A_CTRL) begin
        s_d.rsp.prdata = {24'h0, s_q.lenm1, 1'b0, s_q.op};
      end else if (apb_req.paddr == A_ADDR) begin
        s_d.rsp.prdata = {22'h0, s_q.sel, s_q.waddr};
      end else if (apb_req.paddr == A_STAT) begin
        s_d.rsp.prdata = {27'h0, s_q.ptr_ok, s_q.err, s_q.nack, s_q.done,
                          s_q.st != ST_IDLE};
      end else if (apb_req.paddr == A_RDATA) begin
        s_d.rsp.prdata = {24'h0, s_q.rdata};
      end else if (mapped && apb_req.paddr >= A_BUF0) begin
        s_d.rsp.prdata = {24'h0, s_q.wbuf[buf_idx(apb_req.paddr)]};
      end
    end
    // register writes
    if (wr) begin
      if (apb_req.paddr == A_CTRL && s_q.st == ST_IDLE) begin
        s_d.op    = apb_req.pwdata[2:0];
        s_d.lenm1 = apb_req.pwdata[7:4];
      end else if (apb_req.paddr == A_ADDR && s_q.st == ST_IDLE) begin
        s_d.waddr = apb_req.pwdata[7:0];
        s_d.sel   = apb_req.pwdata[9:8];
      end else if (apb_req.paddr == A_STAT) begin
        // write one to clear; later sets win
        if (apb_req.pwdata[1]) s_d.done = 1'b0;
        if (apb_req.pwdata[2]) s_d.nack = 1'b0;
        if (apb_req.pwdata[3]) s_d.err  = 1'b0;
      end else if (mapped && apb_req.paddr >= A_BUF0 && s_q.st == ST_IDLE) begin
        s_d.wbuf[buf_idx(apb_req.paddr)] = apb_req.pwdata[7:0];
      end
    end
    // pin drive follows step and phase, one cycle late
    s_d.scl_oe = s_q.st == ST_RUN && kind != K_END
               && (s_q.ph == 2'd0 || (s_q.ph == 2'd3 && kind != K_STOP));
    s_d.sda_oe = 1'b0;
    if (s_q.st == ST_RUN) begin
      case (kind)
        K_START: s_d.sda_oe = s_q.ph[1];
        K_STOP:  s_d.sda_oe = !s_q.ph[1];
        K_TX:    s_d.sda_oe = s_q.bitn < 4'd8 && !s_q.sh[7];
        default: s_d.sda_oe = 1'b0;
      endcase
    end
    // operation sequencer
    unique case (s_q.st)
      ST_IDLE: begin
        if (go) begin
          if (apb_req.pwdata[2:0] > OP_CSRWR) begin
            s_d.err = 1'b1;
          end else if (apb_req.pwdata[2:0] == OP_CURRD && !s_q.ptr_ok) begin
            s_d.err = 1'b1;
          end else if (apb_req.pwdata[2:0] == OP_WIPER
                       && s_q.sel[1] == s_q.sel[0]) begin
            s_d.err = 1'b1;
          end else begin
            s_d.st    = ST_RUN;
            s_d.step  = 5'd0;
            s_d.ph    = 2'd0;
            s_d.qcnt  = 8'h00;
            s_d.bitn  = 4'd0;
            s_d.abort = 1'b0;
          end
        end
      end
      ST_RUN: begin
        if (!tick) begin
          // hold while the far end stretches the clock
          if (s_q.qcnt != 8'(SCL_Q - 1)) s_d.qcnt = s_q.qcnt + 8'h01;
        end else begin
          s_d.qcnt = 8'h00;
          s_d.ph   = s_q.ph + 2'd1;
          // sample while the clock is high
          if (s_q.ph == 2'd2 && kind == K_TX && s_q.bitn == 4'd8 && s_q.sda_s) begin
            s_d.abort = 1'b1;
            s_d.nack  = 1'b1;
          end
          if (s_q.ph == 2'd2 && kind == K_RX && s_q.bitn < 4'd8) begin
            s_d.sh = {s_q.sh[6:0], s_q.sda_s};
          end
          // end of a bit
          if (s_q.ph == 2'd3) begin
            case (kind)
              K_START: begin
                s_d.step = s_q.step + 5'd1;
                s_d.sh   = tx_byte(s_q.op, s_q.step + 5'd1, s_q.waddr, s_q.sel, s_q.wbuf);
              end
              K_TX: begin
                if (s_q.bitn == 4'd8) begin
                  // next step only after the acknowledge clock
                  s_d.bitn = 4'd0;
                  s_d.step = s_q.step + 5'd1;
                  s_d.sh   = tx_byte(s_q.op, s_q.step + 5'd1, s_q.waddr, s_q.sel,
                                     s_q.wbuf);
                end else begin
                  s_d.bitn = s_q.bitn + 4'd1;
                  s_d.sh   = {s_q.sh[6:0], 1'b0};
                end
              end
              K_RX: begin
                if (s_q.bitn == 4'd8) begin
                  s_d.bitn = 4'd0;
                  s_d.step = s_q.step + 5'd1;
                  // top bit of the 100-tap wiper is undefined
                  s_d.rdata = (s_q.op == OP_WIPER && s_q.sel == SEL_100)
                            ? {1'b0, s_q.sh[6:0]} : s_q.sh;
                end else begin
                  s_d.bitn = s_q.bitn + 4'd1;
                end
              end
              K_STOP: begin
                s_d.done = 1'b1;
                s_d.st   = ST_IDLE;
                // pointer is known after eeprom traffic only
                if (s_q.op == OP_WIPER || s_q.op == OP_CSRWR) begin
                  s_d.ptr_ok = 1'b0;
                end else if (!s_q.abort) begin
                  s_d.ptr_ok = 1'b1;
                end
                // completed writes start a device write cycle
                if (!s_q.abort && (s_q.op == OP_WRITE || s_q.op == OP_CSRWR)) begin
                  s_d.st   = ST_WAIT;
                  s_d.wcnt = 17'(WR_WAIT_CYC - 1);
                end
              end
              default: s_d.st = ST_IDLE;
            endcase
          end
        end
      end
      ST_WAIT: begin
        // link stays released during the device write
        if (s_q.wcnt == 17'h00000) s_d.st = ST_IDLE;
        else s_d.wcnt = s_q.wcnt - 17'h00001;
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) s_q <= '0;
    else s_q <= s_d;
  end

  assign apb_rsp = s_q.rsp;
  assign scl_o   = s_q.pin_lo;
  assign scl_oe  = s_q.scl_oe;
  assign sda_o   = s_q.pin_lo;
  assign sda_oe  = s_q.sda_oe;

  // checks
  property p_wait_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == ST_WAIT |=> !s_q.sda_oe && !s_q.scl_oe;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("pins driven in write wait");

  property p_wait_len;
    @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == ST_RUN ##1 s_q.st == ST_WAIT |-> s_q.wcnt == 17'(WR_WAIT_CYC - 1);
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("write wait length wrong");

  property p_curr_refuse;
    @(posedge ref_clk) disable iff (!rst_n)
      go && s_q.st == ST_IDLE && apb_req.pwdata[2:0] == OP_CURRD && !s_q.ptr_ok
      |=> s_q.st == ST_IDLE && s_q.err;
  endproperty
  a_curr_refuse: assert property (p_curr_refuse) else $error("current read not refused");

  property p_sel_refuse;
    @(posedge ref_clk) disable iff (!rst_n)
      go && s_q.st == ST_IDLE && apb_req.pwdata[2:0] == OP_WIPER
      && s_q.sel[1] == s_q.sel[0] |=> s_q.err && s_q.st == ST_IDLE;
  endproperty
  a_sel_refuse: assert property (p_sel_refuse) else $error("reserved select started");

  property p_rx_nack;
    @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == ST_RUN && kind == K_RX && s_q.bitn == 4'd8 |=> !s_q.sda_oe;
  endproperty
  a_rx_nack: assert property (p_rx_nack) else $error("ninth read bit driven");

  property p_nack_abort;
    @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == ST_RUN && tick && s_q.ph == 2'd2 && kind == K_TX && s_q.bitn == 4'd8
      && s_q.sda_s |=> s_q.abort && s_q.nack;
  endproperty
  a_nack_abort: assert property (p_nack_abort) else $error("nack not acted on");

  property p_stop_after_ack;
    @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == ST_RUN && kind != K_STOP ##1 s_q.st == ST_RUN && kind == K_STOP
      |-> $past(s_q.bitn) == 4'd8 && $past(s_q.ph) == 2'd3;
  endproperty
  a_stop_after_ack: assert property (p_stop_after_ack) else $error("stop inside a byte");

  property p_apb_ready;
    @(posedge ref_clk) disable iff (!rst_n)
      setup |=> s_q.rsp.pready ##1 !s_q.rsp.pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing wrong"); // apb timing
endmodule

// ---- testbench/sewa_dev_model.sv ----
// Purpose: behavioural two-wire eeprom/wiper device on the far side
// Assumes: open-drain wires resolved by the bench; scl made by the host
// Notes:   lock bits and write enable come from control register writes
`timescale 1ns/1ps
module sewa_dev_model #(
  parameter int         BUSY_NS = 600,    // internal write time
  parameter logic [7:0] WIP_LO  = 8'h25,  // 100-tap wiper value
  parameter logic [7:0] WIP_HI  = 8'hC3   // 256-tap wiper value
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic wp,
  input  wire logic slow,
  output logic      sda_pull,
  output logic      scl_pull
);
  logic [7:0]  mem [256];  // array
  logic [7:0]  pnd [16];   // page buffer
  logic [15:0] vm;         // page buffer valid
  logic [7:0]  sh, wa, ob, ptr, dv;
  logic [6:0]  dev;
  logic [3:0]  cnt, pos;
  logic [1:0]  idx, lk, sel;
  logic        act, rd, rdp, ack, write_enable_latch, busy, bad, setn, tgl, nb;
  initial begin
    foreach (mem[i]) mem[i] = 8'(i);
    ptr = 'x;  // undefined at power-up
    {sda_pull, scl_pull, act, busy, write_enable_latch, lk, bad, setn, nb, vm, tgl} = '0;
    tgl = 1'b1;
  end
  // start or repeated start, ignored while writing
  always @(negedge sda) if (scl === 1'b1 && !busy) begin
    {act, cnt, idx, rd, rdp, sda_pull} = {1'b1, 4'h0, 2'h0, 3'b0};
  end
  // stop: commit only at a clean byte boundary
  always @(posedge sda) if (scl === 1'b1 && !busy) begin
    if (act && dev == 7'h50 && !rd && cnt == 1 && nb && !wp) begin
      for (int i = 0; i < 16; i++) if (vm[i]) mem[{wa[7:4], 4'(i)}] = pnd[i];
      ptr = {wa[7:4], pos};
      busy = 1'b1;
      busy <= #BUSY_NS 1'b0;
    end else if (act && dev == 7'h50 && !rd && idx == 2 && cnt == 1) ptr = wa;
    if (act && dev == 7'h52 && cnt == 1 && nb) begin
      write_enable_latch = dv[1];
      if (!dv[2]) lk = dv[4:3];
    end
    {act, sda_pull, setn, nb} = '0;
  end
  // sample on rising clock
  always @(posedge scl) if (act && !busy) begin
    if (cnt == 8) begin
      cnt = 0;
      if (rd && sda) act = 1'b0;
      if (!rd && !ack) act = 1'b0;
      if (rdp) {rd, rdp} = 2'b10;
    end else begin
      if (!rd) sh = {sh[6:0], sda};
      cnt++;
      if (cnt == 8 && !rd) begin
        ack = 1'b1;
        if (idx == 0) begin
          dev = sh[7:1];
          ack = dev inside {7'h50, 7'h57, 7'h52};
          if (dev != 7'h50) bad = 1'b1;
          rdp = sh[0] && ack;
          if (sh[0] && dev == 7'h50) begin
            ack = ack && (setn || !bad);
            if (setn) {ptr, bad} = {wa, 1'b0};
            ob = mem[ptr];
            ptr++;
          end else if (sh[0]) begin
            ob = (sel == 1) ? {tgl, WIP_LO[6:0]} : WIP_HI;
            tgl = ~tgl;
          end
        end else if (idx == 1) begin
          {wa, sel, pos, vm, nb} = {sh, sh[1:0], sh[3:0], 17'h0};
          setn = (dev == 7'h50);
          if (dev == 7'h57) ack = (sel == 1 || sel == 2);
          if (dev == 7'h50) ack = !(lk == 3 || lk == 2 && sh[7] || lk == 1 && &sh[7:6]);
        end else begin
          ack = (dev == 7'h52) ? !nb : (write_enable_latch && !wp);
          if (ack) {pnd[pos], vm[pos], nb, dv} = {sh, 2'b11, sh};
          if (ack) pos++;
        end
        idx = (idx == 2) ? 2'h2 : idx + 2'h1;
      end
    end
  end
  // drive on falling clock, msb first; optional stretch after each byte
  always @(negedge scl) if (act && !busy) begin
    if (rd) sda_pull = (cnt < 8) ? !ob[3'(4'd7 - cnt)] : 1'b0;
    else sda_pull = (cnt == 8) && ack;
    if (cnt == 8 && slow) begin
      scl_pull = 1'b1;
      scl_pull <= #8000 1'b0;  // outlasts the host's own low time
    end
  end
endmodule

// ---- testbench/sewa_host_tb.sv ----
// Purpose: self-checking bench for the two-wire eeprom/wiper host
// Assumes: device model on the far side of the open-drain wires
// Notes:   short write wait; a reference array predicts each eeprom read
`timescale 1ns/1ps
module sewa_host_tb;
  import sewa_pkg::*;
  localparam logic [7:0] WLO = 8'h25;  // 100-tap wiper in the model
  localparam logic [7:0] WHI = 8'hC3;  // 256-tap wiper in the model
  logic          ref_clk, rst_n, wp, slow, rerr;
  sewa_apb_req_t req;
  sewa_apb_rsp_t rsp;
  logic          scl_oe, sda_oe, scl_pull, sda_pull, scl_o, sda_o;
  logic [31:0]   rv;
  logic [16:0]   seed = 17'd77587;
  wire           scl_w = (scl_oe ? scl_o : 1'b1) && !scl_pull;  // pull-up wires
  wire           sda_w = (sda_oe ? sda_o : 1'b1) && !sda_pull;
  int            mismatches = 0, total_checks = 0, cyc = 0;
  int            ref_mem [256];  // reference array
  int            q [$];          // page data sent
  sewa_host #(.WR_WAIT_CYC(20)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .apb_req(req),
    .apb_rsp(rsp), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe));
  sewa_dev_model #(.BUSY_NS(600), .WIP_LO(WLO), .WIP_HI(WHI)) dev (.scl(scl_w), .sda(sda_w),
    .wp(wp),
    .slow(slow), .sda_pull(sda_pull), .scl_pull(scl_pull));
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic give_verdict;
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    @(posedge ref_clk);
    while (rsp.pready !== 1'b1) @(posedge ref_clk);
    rv = rsp.prdata;
    rerr = rsp.pslverr;
    req <= '0;
  endtask
  task automatic fill(input int n);
    q = {};
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      q.push_back(int'(seed[7:0]));
      apb(1'b1, A_BUF0 + 8'(4 * i), 32'(seed[7:0]));
    end
  endtask
  // start an operation, wait for idle, check flags and read data
  task automatic run(input logic [2:0] op, input int n, input logic [9:0] ad,
                     input logic [1:0] ex, input int er);
    apb(1'b1, A_ADDR, 32'(ad));
    apb(1'b1, A_CTRL, (32'h1 << GO_BIT) | 32'((n - 1) << 4) | 32'(op));
    rv = 32'h1;
    while (rv[0] !== 1'b0) apb(1'b0, A_STAT, 32'h0);
    chk("stat flags", 32'(rv[3:2]), 32'(ex));
    apb(1'b0, A_RDATA, 32'h0);
    if (er >= 0) chk("rdata", 32'(rv[7:0]), 32'(er));
    apb(1'b1, A_STAT, 32'hE);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 99000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    {rst_n, wp, slow, req} = '0;
    foreach (ref_mem[i]) ref_mem[i] = i;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, A_STAT, 32'h0);
    chk("stat reset", 32'(rv[4:0]), 32'h0);
    apb(1'b0, 8'h50, 32'h0);
    chk("pslverr", 32'(rerr), 32'h1);
    run(OP_CURRD, 1, 10'h000, 2'b10, -1);
    fill(1);
    run(OP_WRITE, 1, 10'h030, 2'b01, -1);
    apb(1'b1, A_BUF0, 32'h02);
    run(OP_CSRWR, 1, 10'h000, 2'b00, -1);
    fill(5);
    run(OP_WRITE, 5, 10'h00E, 2'b00, -1);
    foreach (q[i]) ref_mem[{4'h0, 4'(14 + i)}] = q[i];
    run(OP_RANDRD, 1, 10'h00F, 2'b00, ref_mem[15]);
    slow <= 1'b1;
    run(OP_CURRD, 1, 10'h000, 2'b00, ref_mem[16]);
    slow <= 1'b0;
    run(OP_SETADDR, 1, 10'h000, 2'b00, -1);
    run(OP_CURRD, 1, 10'h000, 2'b00, ref_mem[0]);
    run(OP_WIPER, 1, 10'h100, 2'b00, WLO & 8'h7F);
    run(OP_WIPER, 1, 10'h200, 2'b00, WHI);
    run(OP_CURRD, 1, 10'h000, 2'b10, -1);
    for (int s = 0; s < 4; s += 3) run(OP_WIPER, 1, 10'(s << 8), 2'b10, -1);
    wp <= 1'b1;
    fill(1);
    run(OP_WRITE, 1, 10'h0FF, 2'b01, -1);
    wp <= 1'b0;
    run(OP_RANDRD, 1, 10'h0FF, 2'b00, ref_mem[255]);
    give_verdict();
  end
endmodule
